// *** logic/aidm_route_map.v ***
// Purpose: agent identifier destination map with APB access and two lookup ports
// Assumes: APB slave, zero wait states; lookups are synchronous single-cycle requests
// Notes:   function-level reset does not touch the map; only presetn clears it

`include "aidm_consts.vh"

module aidm_route_map #(
	parameter N_AGENTS = 16,
	parameter ID_W     = 4
) (
	input  wire            pclk,
	input  wire            presetn,
	input  wire            psel,
	input  wire            penable,
	input  wire            pwrite,
	input  wire [11:0]     paddr,
	input  wire [31:0]     pwdata,
	output reg  [31:0]     prdata,
	output reg             pready,
	output reg             pslverr,
	input  wire            flr_req,
	input  wire            in_req,
	input  wire [ID_W-1:0] in_id,
	output reg             in_ack,
	output reg             in_hit,
	output reg             in_local,
	output reg  [3:0]      in_port,
	output reg  [4:0]      in_group,
	output reg  [5:0]      in_link,
	input  wire            out_req,
	input  wire [ID_W-1:0] out_id,
	output reg             out_ack,
	output reg             out_hit,
	output reg  [3:0]      out_port,
	output reg  [4:0]      out_group,
	output reg  [5:0]      out_link,
	output reg             lookup_err
);
	// ********************************
	// storage and write sanitising
	// ********************************
	reg [31:0] map_q [0:N_AGENTS-1];
	reg        lookup_en_q;
	reg        err_seen_q;

	wire       access = psel && penable;
	wire       is_entry = (paddr < `AIDM_ENTRY_SPAN);
	wire [9:0] widx = paddr[11:2];
	wire       idx_ok = ({22'h000000, widx} < N_AGENTS);

	// local destinations force port, count and link to zero
	function [31:0] clean_entry;
		input [31:0] w;
		begin
			clean_entry = w;
			if (!w[`AIDM_BIT_KIND]) begin
				clean_entry[`AIDM_PORT_MSB:`AIDM_PORT_LSB] = `AIDM_PORT_ZERO; // R14
				clean_entry[`AIDM_AGG_MSB:`AIDM_AGG_LSB]   = `AIDM_AGG_NONE; // R04
				clean_entry[`AIDM_LINK_MSB:`AIDM_LINK_LSB] = `AIDM_LINK_ZERO; // R07
			end
			clean_entry[3:2] = 2'b00;
			clean_entry[9:8] = 2'b00;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < N_AGENTS; g = g + 1) begin : gen_entry
			// flr_req deliberately absent: entries survive function-level reset
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					map_q[g] <= `AIDM_ENTRY_RESET; // R04 R07 R12
				end else if (access && pwrite && is_entry && widx == g) begin
					map_q[g] <= clean_entry(pwdata); // R15
				end
			end
		end
	endgenerate

	// ********************************
	// apb slave
	// ********************************
	reg [31:0] rd_d;
	reg        err_d;

	always @* begin
		rd_d  = 32'h00000000;
		err_d = 1'b0;
		if (is_entry) begin
			if (idx_ok)
				rd_d = map_q[widx[ID_W-1:0]];
			else
				err_d = 1'b1;
		end else if (paddr == `AIDM_REG_CTRL) begin
			rd_d = {31'h00000000, lookup_en_q};
		end else if (paddr == `AIDM_REG_STATUS) begin
			rd_d = {31'h00000000, err_seen_q};
		end else begin
			err_d = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			lookup_en_q <= 1'b1;
		end else begin
			// answer in the access cycle itself: pready high on first penable edge
			pready  <= psel && !penable;
			pslverr <= psel && !penable && err_d;
			prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h00000000;
			if (access && pwrite && paddr == `AIDM_REG_CTRL)
				lookup_en_q <= pwdata[0];
		end
	end

	// ********************************
	// lookups
	// ********************************
	wire        ih, ip, ib, oh, op, ob;
	wire [3:0]  ipt, opt;
	wire [4:0]  igr, ogr;
	wire [5:0]  ilk, olk;

	aidm_lookup u_in (
		.entry      (map_q[in_id]),
		.hit        (ih),
		.to_port    (ip),
		.first_port (ipt),
		.group_size (igr),
		.link       (ilk),
		.bad_entry  (ib)
	);

	aidm_lookup u_out (
		.entry      (map_q[out_id]),
		.hit        (oh),
		.to_port    (op),
		.first_port (opt),
		.group_size (ogr),
		.link       (olk),
		.bad_entry  (ob)
	);

	wire in_ok  = lookup_en_q && ih && !ib;
	wire out_ok = lookup_en_q && oh && op && !ob;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_ack <= 1'b0; in_hit <= 1'b0; in_local <= 1'b0;
			in_port <= 4'h0; in_group <= 5'h00; in_link <= 6'h00;
			out_ack <= 1'b0; out_hit <= 1'b0;
			out_port <= 4'h0; out_group <= 5'h00; out_link <= 6'h00;
			lookup_err <= 1'b0;
			err_seen_q <= 1'b0;
		end else begin
			in_ack   <= in_req; // R08
			in_hit   <= in_req && in_ok;
			in_local <= in_req && in_ok && !ip;
			in_port  <= in_req ? ipt : 4'h0;
			in_group <= in_req ? igr : 5'h00;
			in_link  <= in_req ? ilk : 6'h00;
			out_ack   <= out_req; // R09
			// local destinations between agents are routed elsewhere, so only port hits count
			out_hit   <= out_req && out_ok; // R11
			out_port  <= out_req ? opt : 4'h0;
			out_group <= out_req ? ogr : 5'h00;
			out_link  <= out_req ? olk : 6'h00;
			lookup_err <= (in_req && ih && ib) || (out_req && oh && ob);
			// set wins over the software clear
			if ((in_req && ih && ib) || (out_req && oh && ob))
				err_seen_q <= 1'b1;
			else if (access && pwrite && paddr == `AIDM_REG_STATUS && pwdata[0])
				err_seen_q <= 1'b0;
		end
	end
endmodule

// *** common/aidm_consts.vh ***
// Purpose: constants for the agent identifier destination map entry block
// Assumes: 32-bit APB register bus, 10 MHz pclk
// Notes:   one entry per agent identifier, one aligned word per entry
//
// Overview of operation
// R01 - non-zero aggregation count means field value plus one ports, a power of two
// R02 - count zero disables aggregation; 1h,3h,7h,Fh valid; other values reserved
// R03 - port select is group first port; members follow consecutively, unaligned allowed
// R04 - aggregation count resets to zero; held zero for local destinations
// R05 - link selector bits 20:15 select link 0 to 63
// R06 - software programs identical link on all ports of an aggregated group
// R07 - link selector resets to zero; held zero for local destinations
// R08 - inbound port lookups give next-hop port and link or local destination
// R09 - outbound agent lookups give egress port and link
// R10 - each index names one destination agent, never home and slave together
// R11 - clearing an entry need not block on-chip agent to agent routing
// R12 - bit 0 is mapping valid flag, clears on reset
// R13 - bit 1 selects destination kind: zero local, one port
// R14 - bits 7:4 select egress port; aggregated base must leave room for group
// R15 - reserved bits 14 and 31:21 read back as written, no routing effect
`ifndef AIDM_CONSTS_VH
`define AIDM_CONSTS_VH

`define AIDM_BIT_VALID      0
`define AIDM_BIT_KIND       1
`define AIDM_PORT_LSB       4
`define AIDM_PORT_MSB       7
`define AIDM_AGG_LSB        10
`define AIDM_AGG_MSB        13
`define AIDM_LINK_LSB       15
`define AIDM_LINK_MSB       20
`define AIDM_RSVD_BIT       14
`define AIDM_RSVD_LSB       21
`define AIDM_RSVD_MSB       31
`define AIDM_ENTRY_RESET    32'h00000000
`define AIDM_AGG_NONE       4'h0
`define AIDM_AGG_2          4'h1
`define AIDM_AGG_4          4'h3
`define AIDM_AGG_8          4'h7
`define AIDM_AGG_16         4'hF
`define AIDM_LINK_ZERO      6'h00
`define AIDM_PORT_ZERO      4'h0
`define AIDM_REG_CTRL       12'hF00
`define AIDM_REG_STATUS     12'hF04
`define AIDM_ENTRY_SPAN     12'h800

`endif

// *** logic/aidm_lookup.v ***
// Purpose: decodes one map entry into a routing answer
// Assumes: entry word laid out as in the constants header
// Notes:   purely combinational; registered by the caller

`include "aidm_consts.vh"

module aidm_lookup (
	input  wire [31:0] entry,
	output reg         hit,
	output reg         to_port,
	output reg  [3:0]  first_port,
	output reg  [4:0]  group_size,
	output reg  [5:0]  link,
	output reg         bad_entry
);
	reg [3:0] agg;
	reg       agg_ok;
	reg [4:0] last_port;

	always @* begin
		agg        = entry[`AIDM_AGG_MSB:`AIDM_AGG_LSB];
		hit        = entry[`AIDM_BIT_VALID]; // R12
		to_port    = entry[`AIDM_BIT_KIND]; // R13
		first_port = entry[`AIDM_PORT_MSB:`AIDM_PORT_LSB]; // R03 R14
		link       = entry[`AIDM_LINK_MSB:`AIDM_LINK_LSB]; // R05
		// R02
		agg_ok = (agg == `AIDM_AGG_NONE) || (agg == `AIDM_AGG_2) ||
			(agg == `AIDM_AGG_4) || (agg == `AIDM_AGG_8) || (agg == `AIDM_AGG_16);
		group_size = {1'b0, agg} + 5'h01; // R01
		last_port  = {1'b0, first_port} + {1'b0, agg}; // R14
		bad_entry  = hit && to_port && (!agg_ok || last_port[4]);
		if (!to_port) begin
			// local destinations carry no port, link or group
			first_port = `AIDM_PORT_ZERO;
			link       = `AIDM_LINK_ZERO;
			group_size = 5'h01;
		end
	end
endmodule

// *** testbench/aidm_route_map_assertions.sv ***
// Purpose: port checks on the route map lookups
// Assumes: each lookup is answered one cycle after its request
// Notes:   bound from the bench top file
module aidm_route_map_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       in_req,
	input wire logic       in_ack,
	input wire logic       in_hit,
	input wire logic       in_local,
	input wire logic [3:0] in_port,
	input wire logic [4:0] in_group,
	input wire logic [5:0] in_link,
	input wire logic       out_req,
	input wire logic       out_ack,
	input wire logic       out_hit,
	input wire logic [3:0] out_port,
	input wire logic [4:0] out_group
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// lookup answers
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	in_answer_a: assert property (in_req |=> in_ack)
		else $error("inbound lookup unanswered");
	out_answer_a: assert property (out_req |=> out_ack)
		else $error("outbound lookup unanswered");
	in_idle_a: assert property (!in_req |=> !in_ack)
		else $error("inbound answer without request");
	in_size_a: assert property (in_ack && in_hit && !in_local |-> in_group inside {1, 2, 4, 8, 16})
		else $error("inbound group size bad");
	out_size_a: assert property (out_ack && out_hit |-> out_group inside {1, 2, 4, 8, 16})
		else $error("outbound group size bad");
	in_room_a: assert property (in_ack && in_hit && !in_local |-> in_port + in_group <= 5'd16)
		else $error("inbound group overflows");
	out_room_a: assert property (out_ack && out_hit |-> out_port + out_group <= 5'd16)
		else $error("outbound group overflows");
	local_zero_a: assert property (in_ack && in_local |-> in_port == 0 && in_link == 0)
		else $error("local answer carries port or link");
endmodule

// *** testbench/aidm_agent_model.sv ***
// Purpose: agents and ports that consult the map
// Assumes: one lookup on each side per go pulse
// Notes:   idle index toggles so a stale index never looks valid
module aidm_agent_model (
	input  wire logic       pclk,
	input  wire logic       go,
	input  wire logic [3:0] sel,
	output logic            in_req,
	output logic [3:0]      in_id,
	output logic            out_req,
	output logic [3:0]      out_id
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		in_req = 0;
		out_req = 0;
		in_id = 0;
		out_id = 0;
	end
	always @(posedge pclk) begin
		in_req <= go;
		out_req <= go;
		in_id <= go ? sel : ~in_id;
		out_id <= go ? sel : ~out_id;
	end
endmodule

// *** testbench/agent_id_route_map_entry_tb_top.sv ***
// Purpose: self-checking bench for the route map
// Assumes: APB master waits for pready; lookups via the agent model
// Notes:   expected entries kept in an integer array
module agent_id_route_map_entry_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flr_req = 0, go = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0]  sel = 0, in_id, out_id, in_port, out_port;
	logic [4:0]  in_group, out_group;
	logic [5:0]  in_link, out_link;
	logic        pready, pslverr, e, in_req, out_req, in_ack, in_hit, in_local;
	logic        out_ack, out_hit, lookup_err;
	int          bad_count = 0, tests_run = 0, ent[16];
	always #50 pclk = ~pclk;
	aidm_route_map u_dut (.*);
	aidm_agent_model u_agent (.*);
	task automatic chk(input string n, input logic [31:0] s, x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(input logic w, input int a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= 12'(a);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (!pready);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one lookup from both sides; returns while the answer stands
	task automatic look(input int id);
		@(posedge pclk);
		go <= 1;
		sel <= 4'(id);
		@(posedge pclk);
		go <= 0;
		do @(negedge pclk); while (!in_ack);
	endtask
	// ****
	// one entry: write, read back, look up from both sides
	// ****
	task automatic entry(input int id, v, k, c, b);
		int sz, lk, w, ok;
		sz = c + 1;
		if (b < 0) b = $urandom % (17 - sz);
		lk = $urandom % 64;
		w = ($urandom & 32'hFFE0430C) | lk << 15 | c << 10 | b << 4 | k << 1 | v;
		ent[id] = k ? w & ~32'h30C : w & ~32'h1FBFFC;
		ok = v && k && c inside {0, 1, 3, 7, 15} && b + sz <= 16;
		apb(1, id * 4, w);
		apb(0, id * 4, 0);
		chk("entry", r, ent[id]);
		look(id);
		chk("out hit", out_hit, ok);
		chk("local", in_local, v && !k);
		chk("err", lookup_err, v && k && !ok);
		chk("in hit", in_hit, k ? ok : v);
		if (ok) begin
			chk("port", {out_port, in_port}, {b[3:0], b[3:0]});
			chk("size", {out_group, in_group}, {sz[4:0], sz[4:0]});
			chk("link", {out_link, in_link}, {lk[5:0], lk[5:0]});
		end else if (v && !k) begin
			// local answer: no port, single member, no link
			chk("local route", {in_port, in_group, in_link}, 15'h0040);
		end
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'hBD2B91F4));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 16; i++) begin
			apb(0, i * 4, 0);
			chk("reset", r, 0);
		end
		for (int i = 0; i < 5; i++) entry(i, 1, 1, (1 << i) - 1, -1);
		entry(5, 1, 1, 2, 0);
		entry(6, 1, 1, 3, 13);
		entry(7, 1, 0, 7, 9);
		entry(8, 0, 1, 1, 2);
		// entries 5 and 6 raised the sticky error; write one clears it
		apb(0, 12'hF04, 0);
		chk("sticky", r, 1);
		apb(1, 12'hF04, 1);
		apb(0, 12'hF04, 0);
		chk("sticky clear", r, 0);
		apb(0, 12'hF00, 0);
		chk("enable", r, 1);
		apb(1, 12'hF00, 0);
		look(0);
		chk("disabled", {in_hit, out_hit, in_ack}, 1);
		apb(1, 12'hF00, 1);
		// index past the map is refused
		apb(0, 12'h040, 0);
		chk("refused", {r[30:0], e}, 1);
		flr_req <= 1;
		apb(0, 4, 0);
		chk("flr", r, ent[1]);
		@(posedge pclk);
		presetn <= 0;
		flr_req <= 0;
		@(posedge pclk);
		presetn <= 1;
		apb(0, 4, 0);
		chk("cleared", r, 0);
		report_and_stop;
	end
endmodule
bind aidm_route_map aidm_route_map_chk u_chk (.*);
